// ---- rtl/suspend_irq_defines.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SUSPEND_IRQ_DEFINES_SVH
`define SUSPEND_IRQ_DEFINES_SVH
`define ADDR_W 10
`define OFS_IRQ_STATUS 10'h310
`define OFS_IRQ_ENABLE 10'h314
`define OFS_POWER_DOWN 10'h354
`define OFS_WAKE_COUNT 10'h358
`define BIT_OC2_OFF 2
`define BIT_OC1_OFF 1
`define BIT_CLK_KEEP 0
`define PWR_RESET 3'h0
`define IRQ_RESET 32'h0000_0000
`define CLK_MHZ 200
`define WAKE32_NS 10000
`define WAKE16_NS 50000000
// Divide first so the product stays inside 32 bits
`define WAKE32_CYCLES ((`WAKE32_NS / 1000) * `CLK_MHZ)
`define WAKE16_CYCLES ((`WAKE16_NS / 1000) * `CLK_MHZ)
`define CLK_STABLE_BIT 6
`endif

// ---- rtl/suspend_irq_pkg.sv ----
// Types shared by the suspend power and interrupt status block
package suspend_irq_pkg;
  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [9:0] addr;
    logic [31:0] wdata;
  } cpu_req_s;
  typedef enum logic [1:0] {awake, suspended, waking} wake_state_e;
endpackage : suspend_irq_pkg

// ---- rtl/suspend_power_and_irq_status.sv ----
// Power-down control bits, wake timing and sticky host interrupt status
`timescale 1ns/10ps
`default_nettype none
`include "suspend_irq_defines.svh"
module suspend_power_and_irq_status #(
  parameter int unsigned WAKE32_CYCLES = `WAKE32_CYCLES,
  parameter int unsigned WAKE16_CYCLES = `WAKE16_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire suspend_irq_pkg::cpu_req_s cpu_req,
  output logic [31:0] cpu_rdata,
  input wire logic bus_width_32,
  input wire logic suspend_request,
  input wire logic [31:0] irq_events,
  input wire logic global_interrupt_enable,
  input wire logic slow_suspend_clock,
  output logic host_irq,
  output logic port1_overcurrent_power_off,
  output logic port2_overcurrent_power_off,
  output logic clocks_stopped,
  output logic slow_clock_only
);
  import suspend_irq_pkg::*;

  if (WAKE32_CYCLES < 1 || WAKE16_CYCLES < 1) begin : gen_bad_wake
    $error("Wake counts must be at least one cycle");
  end

  // ==========================================================
  // Strap capture
  // ==========================================================
  logic width_meta;
  logic width_sync;
  logic [1:0] strap_age;
  logic strap_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      width_meta <= 1'b0;
      width_sync <= 1'b0;
    end else begin
      width_meta <= bus_width_32;
      width_sync <= width_meta;
    end
  end
  // Strap read only after the synchroniser has filled
  wire strap_ready = (strap_age == 2'h2) && !strap_done;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      strap_age <= 2'h0;
      strap_done <= 1'b0;
    end else begin
      if (strap_age != 2'h2) strap_age <= strap_age + 2'h1;
      if (strap_ready) strap_done <= 1'b1;
    end
  end

  // ==========================================================
  // Register decode
  // ==========================================================
  wire wr_en = cpu_req.cs && cpu_req.wr;
  wire rd_en = cpu_req.cs && cpu_req.rd;
  wire wr_status = wr_en && (cpu_req.addr == `OFS_IRQ_STATUS);
  wire wr_enable = wr_en && (cpu_req.addr == `OFS_IRQ_ENABLE);
  wire wr_power = wr_en && (cpu_req.addr == `OFS_POWER_DOWN);
  wire wr_wake = wr_en && (cpu_req.addr == `OFS_WAKE_COUNT);

  logic [31:0] irq_status;
  logic [31:0] irq_enable;
  logic [2:0] power_down;
  logic [31:0] wake_count;
  wake_state_e state;
  logic [31:0] wake_timer;
  logic clock_stable_event;

  // ==========================================================
  // Power-down control and wake count
  // ==========================================================
  wire [31:0] wake_default = width_sync ? WAKE32_CYCLES : WAKE16_CYCLES;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      power_down <= `PWR_RESET;
      wake_count <= 32'h0000_0000;
    end else begin
      if (wr_power) power_down <= cpu_req.wdata[2:0];
      if (strap_ready) wake_count <= wake_default;
      else if (wr_wake) wake_count <= cpu_req.wdata;
    end
  end

  // ==========================================================
  // Suspend and wake sequencing
  // ==========================================================
  wire clk_keep = power_down[`BIT_CLK_KEEP];
  // A zero count would wrap the timer round past 32'hffff_ffff; hold at least one cycle
  wire [31:0] wake_load = (wake_count == 32'h0) ? 32'h1 : wake_count;
  wake_state_e next_state;
  logic [31:0] next_timer;
  always_comb begin
    next_state = state;
    next_timer = wake_timer;
    unique case (state)
      awake: begin
        if (suspend_request) next_state = suspended;
      end
      suspended: begin
        if (!suspend_request) begin
          next_state = clocks_stopped ? waking : awake;
          next_timer = wake_load;
        end
      end
      waking: begin
        next_timer = wake_timer - 32'h1;
        if (wake_timer == 32'h1) next_state = awake;
      end
    endcase
  end
  wire next_stable = (state == waking) && (wake_timer == 32'h1);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= awake;
      wake_timer <= 32'h0;
      clock_stable_event <= 1'b0;
    end else begin
      state <= next_state;
      wake_timer <= next_timer;
      clock_stable_event <= next_stable;
    end
  end

  // ==========================================================
  // Suspend outputs
  // ==========================================================
  wire in_susp = (next_state == suspended);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      clocks_stopped <= 1'b0;
      slow_clock_only <= 1'b0;
      port1_overcurrent_power_off <= 1'b0;
      port2_overcurrent_power_off <= 1'b0;
    end else begin
      clocks_stopped <= in_susp && !clk_keep;
      slow_clock_only <= in_susp && !clk_keep;
      port1_overcurrent_power_off <= in_susp && power_down[`BIT_OC1_OFF];
      port2_overcurrent_power_off <= in_susp && power_down[`BIT_OC2_OFF];
    end
  end

  // ==========================================================
  // Interrupt status
  // ==========================================================
  logic [31:0] stable_vec;
  always_comb begin
    stable_vec = 32'h0;
    stable_vec[`CLK_STABLE_BIT] = clock_stable_event;
  end
  wire [31:0] set_vec = irq_events | stable_vec;
  wire [31:0] clr_vec = wr_status ? cpu_req.wdata : 32'h0;
  // Set wins over a clear in the same cycle
  wire [31:0] next_status = (irq_status & ~clr_vec) | set_vec;
  wire next_irq = global_interrupt_enable && |(irq_status & irq_enable);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irq_status <= `IRQ_RESET;
      irq_enable <= `IRQ_RESET;
      host_irq <= 1'b0;
    end else begin
      irq_status <= next_status;
      if (wr_enable) irq_enable <= cpu_req.wdata;
      host_irq <= next_irq;
    end
  end

  // ==========================================================
  // Read path
  // ==========================================================
  logic [31:0] rd_mux;
  always_comb begin
    unique case (cpu_req.addr)
      `OFS_IRQ_STATUS: rd_mux = irq_status;
      `OFS_IRQ_ENABLE: rd_mux = irq_enable;
      `OFS_POWER_DOWN: rd_mux = {29'h0, power_down};
      `OFS_WAKE_COUNT: rd_mux = wake_count;
      default: rd_mux = 32'h0;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) cpu_rdata <= 32'h0;
    else if (rd_en) cpu_rdata <= rd_mux;
  end

  // ==========================================================
  // Checks
  // ==========================================================
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  AST_OC2_OFF: assert property (port2_overcurrent_power_off |->
    (state == suspended) && $past(power_down[`BIT_OC2_OFF]))
    else $error("Port 2 detector off outside suspend or with bit clear");
  AST_OC1_ON: assert property ((state == suspended) &&
    $past(state == suspended) && !power_down[`BIT_OC1_OFF] &&
    $stable(power_down) |-> !port1_overcurrent_power_off)
    else $error("Port 1 detector off while its bit is clear");
  AST_STOP: assert property ($rose(suspend_request) && (state == awake) &&
    !clk_keep && !wr_power |=> clocks_stopped)
    else $error("Clocks not stopped on suspend entry");
  AST_SLOW: assert property ((slow_clock_only == clocks_stopped) &&
    (!slow_clock_only || ((state == suspended) && !$past(clk_keep))))
    else $error("Slow clock flag disagrees with clock stop");
  AST_READY: assert property ($rose(clock_stable_event) |->
    $past(state == waking) && (state == awake))
    else $error("Clock-ready event without a wake sequence");
  AST_KEEP: assert property (clk_keep && $past(clk_keep) |->
    !clocks_stopped)
    else $error("Clocks stopped while keep bit set");
  AST_STRAP: assert property (strap_ready |=>
    wake_count == (width_sync ? WAKE32_CYCLES : WAKE16_CYCLES))
    else $error("Wake count default wrong for bus width");
  AST_LATCH: assert property (|irq_events |=>
    ((irq_status & $past(irq_events)) == $past(irq_events)))
    else $error("Event not latched into status");
  AST_W1C: assert property (wr_status && (cpu_req.wdata == 32'h0) |=>
    ((irq_status & $past(irq_status)) == $past(irq_status)))
    else $error("Writing zero cleared a status bit");
  AST_GLOBAL: assert property (!global_interrupt_enable |=> !host_irq)
    else $error("Interrupt raised with global enable off");

  COV_WAKE: cover property ((state == waking) ##[1:20] clock_stable_event);
  COV_KEEP: cover property (clk_keep && (state == suspended));
  COV_CLEAR: cover property (wr_status ##1 (irq_status == 32'h0));
  COV_IRQ: cover property ($rose(host_irq));
endmodule : suspend_power_and_irq_status
`default_nettype wire

// ---- tb/cpu_host_model.sv ----
// Host processor model driving the register bus
`timescale 1ns/10ps
`default_nettype none
`include "suspend_irq_defines.svh"
module cpu_host_model (
  input wire logic clk,
  output var suspend_irq_pkg::cpu_req_s cpu_req,
  input wire logic [31:0] cpu_rdata
);
  import suspend_irq_pkg::*;
  initial cpu_req = '0;
  // ==========
  // Bus cycles
  task automatic access(input logic w, input logic [9:0] a,
    input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    cpu_req <= '{cs: 1'b1, rd: !w, wr: w, addr: a, wdata: d};
    @(posedge clk);
    // Released lines show garbage, never the last value
    cpu_req <= '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    #1 q = cpu_rdata;
  endtask : access
  // ==========
  // Start-up sequence
  task automatic init_host();
    logic [31:0] q;
    access(1'b0, `OFS_WAKE_COUNT, '0, q);
    access(1'b1, `OFS_WAKE_COUNT, q, q);
    access(1'b1, `OFS_IRQ_STATUS, 32'hffff_ffff, q);
  endtask : init_host
endmodule : cpu_host_model
`default_nettype wire

// ---- tb/suspend_power_and_irq_status_tb.sv ----
// Self-checking bench for the suspend power and interrupt status block
`timescale 1ns/10ps
`default_nettype none
`include "suspend_irq_defines.svh"
module suspend_power_and_irq_status_tb;
  import suspend_irq_pkg::*;
  // Short wake counts keep the run brief
  localparam int unsigned W32 = 20;
  localparam int unsigned W16 = 50;
  logic clk = 1'b0;
  logic reset = 1'b1;
  cpu_req_s cpu_req;
  logic [31:0] cpu_rdata, q, ev, m;
  logic [31:0] irq_events = '0;
  logic bus_width_32 = 1'b0;
  logic suspend_request = 1'b0;
  logic global_interrupt_enable = 1'b0;
  logic slow_suspend_clock = 1'b0;
  logic host_irq, p1_off, p2_off, clocks_stopped, slow_clock_only;
  logic [2:0] pw;
  int mismatches = 0;
  int checks_done = 0;
  int cycles = 0;
  suspend_power_and_irq_status #(.WAKE32_CYCLES(W32), .WAKE16_CYCLES(W16))
    uut (.clk(clk), .reset(reset), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .bus_width_32(bus_width_32), .suspend_request(suspend_request),
    .irq_events(irq_events), .global_interrupt_enable(global_interrupt_enable),
    .slow_suspend_clock(slow_suspend_clock), .host_irq(host_irq),
    .port1_overcurrent_power_off(p1_off), .port2_overcurrent_power_off(p2_off),
    .clocks_stopped(clocks_stopped), .slow_clock_only(slow_clock_only));
  cpu_host_model host (.clk(clk), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata));
  // ==========
  // Clock, slow clock and hang guard
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles % 64 == 63) slow_suspend_clock <= ~slow_suspend_clock;
    if (cycles == 3000) begin
      mismatches++;
      report_and_stop();
    end
  end
  // ==========
  // Helpers
  function automatic logic [31:0] wake_exp(input logic w32);
    return w32 ? W32 : W16;
  endfunction : wake_exp
  function automatic logic irq_exp(input logic [31:0] e, k, input logic g);
    return g && |(e & k);
  endfunction : irq_exp
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic report_and_stop();
    if (mismatches == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // ==========
  // Scenarios
  initial begin
    q = $urandom(32'h952a);
    for (int w = 0; w < 2; w++) begin
      @(posedge clk);
      reset <= 1'b1;
      bus_width_32 <= w[0];
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      repeat (5) @(posedge clk);
      host.access(1'b0, `OFS_POWER_DOWN, '0, q);
      check(q, 32'h0);
      host.access(1'b0, `OFS_WAKE_COUNT, '0, q);
      check(q, wake_exp(w[0]));
      host.init_host();
      host.access(1'b0, `OFS_WAKE_COUNT, '0, q);
      check(q, wake_exp(w[0]));
    end
    for (int i = 0; i < 6; i++) begin
      ev = $urandom();
      m = $urandom();
      host.access(1'b1, `OFS_IRQ_ENABLE, m, q);
      @(posedge clk);
      global_interrupt_enable <= i[0];
      irq_events <= ev;
      @(posedge clk);
      irq_events <= '0;
      repeat (3) @(posedge clk);
      #1 check({31'h0, host_irq}, {31'h0, irq_exp(ev, m, i[0])});
      // A write of zero must leave every latched bit alone
      host.access(1'b1, `OFS_IRQ_STATUS, '0, q);
      host.access(1'b0, `OFS_IRQ_STATUS, '0, q);
      check(q, ev);
      host.access(1'b1, `OFS_IRQ_STATUS, m, q);
      host.access(1'b0, `OFS_IRQ_STATUS, '0, q);
      check(q, ev & ~m);
      host.access(1'b1, `OFS_IRQ_STATUS, 32'hffff_ffff, q);
    end
    // Every power-down setting, upper bits written as noise
    for (int i = 0; i < 8; i++) begin
      pw = i[2:0];
      host.access(1'b1, `OFS_POWER_DOWN, ($urandom() & ~32'h7) | pw, q);
      host.access(1'b0, `OFS_POWER_DOWN, '0, q);
      check(q, {29'h0, pw});
      @(posedge clk);
      suspend_request <= 1'b1;
      repeat (3) @(posedge clk);
      #1 check({p2_off, p1_off, clocks_stopped, slow_clock_only},
        {pw[2], pw[1], !pw[0], !pw[0]});
      @(posedge clk);
      suspend_request <= 1'b0;
      host.access(1'b0, `OFS_IRQ_STATUS, '0, q);
      check(q, 32'h0);
      repeat (W32 + 4) @(posedge clk);
      host.access(1'b0, `OFS_IRQ_STATUS, '0, q);
      check(q, {25'h0, !pw[0], 6'h0});
      host.access(1'b1, `OFS_IRQ_STATUS, 32'hffff_ffff, q);
    end
    host.access(1'b1, 10'h3fc, $urandom(), q);
    host.access(1'b0, 10'h3fc, '0, q);
    check(q, 32'h0);
    report_and_stop();
  end
endmodule : suspend_power_and_irq_status_tb
`default_nettype wire
